// ==== sram_host_ctrl.v ====
// Host controller driving an asynchronous 128K x 8 static memory
`timescale 1ns/1ps
`include "sram_ctrl_regs.vh"
module sram_host_ctrl #(
	parameter ADDR_WIDTH = `ADDR_WIDTH,
	parameter DATA_WIDTH = `DATA_WIDTH
) (
	input wire i_core_clk,
	input wire i_rst,
	// User request port
	input wire i_req_valid,
	input wire i_req_write,
	input wire [ADDR_WIDTH-1:0] i_req_addr,
	input wire [DATA_WIDTH-1:0] i_req_wdata,
	output wire o_req_ready,
	output reg [DATA_WIDTH-1:0] o_rsp_rdata,
	output reg o_rsp_valid,
	// Power control
	input wire i_retention_req,
	input wire i_supply_ok,
	output wire o_retention_ack,
	// Memory pins
	output reg [ADDR_WIDTH-1:0] o_word_address,
	output reg [DATA_WIDTH-1:0] o_byte_data_pins,
	output reg o_byte_data_pins_oe,
	input wire [DATA_WIDTH-1:0] i_byte_data_pins,
	output reg o_select_active_low_n,
	output reg o_select_active_high,
	output reg o_write_strobe_n,
	output reg o_output_enable_n
);
	// Controller states
	localparam [2:0] ST_POWER = 3'd0; // Supply absent or recovering
	localparam [2:0] ST_IDLE = 3'd1; // Selected idle, outputs off
	localparam [2:0] ST_READ = 3'd2; // Read access in progress
	localparam [2:0] ST_WSETUP = 3'd3; // Address and data placed
	localparam [2:0] ST_WPULSE = 3'd4; // Strobe low
	localparam [2:0] ST_WHOLD = 3'd5; // Strobe released, data held
	localparam [2:0] ST_RETAIN = 3'd6; // Data retention, deselected
	localparam [2:0] ST_TURN = 3'd7; // Output disable before next access

	// Whole-cycle waits, worked out at full width then cut to the timer width
	localparam integer N_READ_I = `CYC_READ;
	localparam integer N_WRITE_I = `CYC_WRITE;
	localparam integer N_GAP_I = `CYC_WRITE_GAP;
	localparam integer N_RECOVER_I = `CYC_RECOVER;
	localparam integer N_TURN_I = `CYC_TURN;
	localparam [`CNT_WIDTH-1:0] N_READ = N_READ_I[`CNT_WIDTH-1:0];
	localparam [`CNT_WIDTH-1:0] N_WRITE = N_WRITE_I[`CNT_WIDTH-1:0];
	localparam [`CNT_WIDTH-1:0] N_GAP = N_GAP_I[`CNT_WIDTH-1:0];
	localparam [`CNT_WIDTH-1:0] N_RECOVER = N_RECOVER_I[`CNT_WIDTH-1:0];
	localparam [`CNT_WIDTH-1:0] N_TURN = N_TURN_I[`CNT_WIDTH-1:0];

	reg [2:0] state_q; // Current state
	reg [2:0] state_d; // Next state
	reg tmr_load; // Start a wait
	reg [`CNT_WIDTH-1:0] tmr_count; // Length of the wait
	wire tmr_done; // Wait expired

	// Shared wait timer for every timed phase
	sram_delay_timer #(
		.WIDTH(`CNT_WIDTH)
	) u_timer (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_load(tmr_load),
		.i_count(tmr_count),
		.o_done(tmr_done)
	);

	// Requests are taken only when selected and idle
	assign o_req_ready = (state_q == ST_IDLE) && !i_retention_req && i_supply_ok;
	assign o_retention_ack = (state_q == ST_RETAIN);

	// Next-state logic
	always @* begin
		state_d = state_q;
		tmr_load = 1'b0;
		tmr_count = {`CNT_WIDTH{1'b0}};
		case (state_q)
			ST_POWER: begin
				// Stay deselected until supply good and recovery over
				if (!i_supply_ok) begin
					tmr_load = 1'b1;
					tmr_count = N_RECOVER;
				end else if (tmr_done) begin
					state_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (!i_supply_ok) begin
					state_d = ST_POWER;
				end else if (i_retention_req) begin
					state_d = ST_RETAIN; // No delay needed
				end else if (i_req_valid) begin
					tmr_load = 1'b1;
					if (i_req_write) begin
						state_d = ST_WSETUP;
						tmr_count = {{(`CNT_WIDTH-1){1'b0}}, 1'b1};
					end else begin
						state_d = ST_READ;
						tmr_count = N_READ;
					end
				end
			end
			ST_READ: begin
				if (tmr_done) begin
					state_d = ST_TURN;
					tmr_load = 1'b1;
					tmr_count = N_TURN;
				end
			end
			ST_WSETUP: begin
				// Address stable before strobe falls
				if (tmr_done) begin
					state_d = ST_WPULSE;
					tmr_load = 1'b1;
					tmr_count = N_WRITE;
				end
			end
			ST_WPULSE: begin
				if (tmr_done) begin
					state_d = ST_WHOLD;
					tmr_load = 1'b1;
					tmr_count = N_GAP;
				end
			end
			ST_WHOLD: begin
				if (tmr_done) begin
					state_d = ST_IDLE;
				end
			end
			ST_RETAIN: begin
				if (!i_supply_ok) begin
					state_d = ST_POWER;
				end else if (!i_retention_req) begin
					state_d = ST_IDLE;
				end
			end
			ST_TURN: begin
				if (tmr_done) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_POWER;
			end
		endcase
		// Supply loss overrides any phase, so no access runs on a ramp
		if (!i_supply_ok) begin
			state_d = ST_POWER;
			tmr_load = 1'b1;
			tmr_count = N_RECOVER;
		end
	end

	// State register
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			state_q <= ST_POWER;
		end else begin
			state_q <= state_d;
		end
	end

	// Pin and response registers
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			o_word_address <= {ADDR_WIDTH{1'b0}};
			o_byte_data_pins <= {DATA_WIDTH{1'b0}};
			o_byte_data_pins_oe <= 1'b0;
			o_select_active_low_n <= 1'b1;
			o_select_active_high <= 1'b0;
			o_write_strobe_n <= 1'b1;
			o_output_enable_n <= 1'b1;
			o_rsp_rdata <= {DATA_WIDTH{1'b0}};
			o_rsp_valid <= 1'b0;
		end else begin
			o_rsp_valid <= 1'b0;
			// Deselect outside active states
			o_select_active_low_n <= !(state_d == ST_IDLE || state_d == ST_READ ||
				state_d == ST_WSETUP || state_d == ST_WPULSE ||
				state_d == ST_WHOLD || state_d == ST_TURN);
			o_select_active_high <= !(state_d == ST_POWER || state_d == ST_RETAIN);
			// Strobe low only inside the write pulse
			o_write_strobe_n <= (state_d != ST_WPULSE);
			// Enable low only during reads; high in write and retention
			o_output_enable_n <= (state_d != ST_READ);
			if (state_q == ST_IDLE && state_d != ST_IDLE && state_d != ST_RETAIN &&
				state_d != ST_POWER) begin
				o_word_address <= i_req_addr;
				o_byte_data_pins <= i_req_wdata;
			end
			// Drive data from setup through hold, past strobe rise
			o_byte_data_pins_oe <= (state_d == ST_WSETUP || state_d == ST_WPULSE ||
				state_d == ST_WHOLD);
			// Sample read data at end of access
			if (state_q == ST_READ && tmr_done) begin
				o_rsp_rdata <= i_byte_data_pins;
				o_rsp_valid <= 1'b1;
			end
		end
	end
endmodule // sram_host_ctrl

// ==== sram_ctrl_regs.vh ====
// Constants and timing counts for the static memory controller
`ifndef SRAM_CTRL_REGS_VH
`define SRAM_CTRL_REGS_VH
`define CLK_PERIOD_NS 100
`define ADDR_WIDTH 17
`define DATA_WIDTH 8
`define T_READ_ACCESS_NS 40
`define T_WRITE_PULSE_NS 28
`define T_WRITE_CYCLE_NS 35
`define T_DATA_SETUP_NS 18
`define T_READ_PERIOD_NS 40
`define T_OE_HIGHZ_NS 10
// Least times round up to whole cycles, never below one
`define NS_TO_CYC(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
	(((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define CYC_READ `NS_TO_CYC(`T_READ_ACCESS_NS)
`define CYC_WRITE `NS_TO_CYC(`T_WRITE_PULSE_NS)
`define CYC_WRITE_GAP `NS_TO_CYC(`T_WRITE_CYCLE_NS - `T_WRITE_PULSE_NS)
`define CYC_RECOVER `NS_TO_CYC(`T_READ_PERIOD_NS)
`define CYC_TURN `NS_TO_CYC(`T_OE_HIGHZ_NS)
`define CNT_WIDTH 4
`endif

// ==== sram_delay_timer.v ====
// Down counter whose flag goes high when a loaded wait expires and stays high until the next load
`timescale 1ns/1ps
module sram_delay_timer #(
	parameter WIDTH = 4
) (
	input wire i_core_clk,
	input wire i_rst,
	input wire i_load,
	input wire [WIDTH-1:0] i_count,
	output wire o_done
);
	reg [WIDTH-1:0] count_q; // Remaining cycles
	reg [WIDTH-1:0] count_d;

	// Next count: load wins, else count toward zero
	always @* begin
		count_d = count_q;
		if (i_load) begin
			count_d = i_count;
		end else if (count_q != {WIDTH{1'b0}}) begin
			count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// Count register
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			count_q <= {WIDTH{1'b0}};
		end else begin
			count_q <= count_d;
		end
	end

	// Expired when the count sits at zero; never looks at the load, which the
	// caller derives from this flag, so no loop through the two can form
	assign o_done = (count_q == {WIDTH{1'b0}});
endmodule // sram_delay_timer

// ==== sram_model.sv ====
// Behavioural 128K x 8 asynchronous static memory
`timescale 1ns/1ps
module sram_model (
	input wire [16:0] i_addr,
	input wire [7:0] i_data,
	input wire i_sel_n, i_sel, i_we_n, i_oe_n,
	output wire [7:0] o_data,
	output wire o_drive
);
	logic [7:0] mem [0:131071];
	// Write interval is the overlap of both selects and the strobe
	wire wr = !i_sel_n && i_sel && !i_we_n;
	// Store on whichever edge ends the interval
	always @(negedge wr) mem[i_addr] <= i_data;
	// Drives only in read mode, so writes and deselect float the pins
	assign o_drive = !i_sel_n && i_sel && i_we_n && !i_oe_n;
	// Data follows the address after the access time
	assign #40 o_data = mem[i_addr];
endmodule // sram_model

// ==== sram_host_chk.sv ====
// Pin timing checks for the memory host controller
`timescale 1ns/1ps
module sram_host_chk (
	input wire i_core_clk, i_rst, i_req_valid, i_req_write, o_req_ready, o_rsp_valid,
	input wire i_supply_ok, o_retention_ack, o_byte_data_pins_oe, o_select_active_low_n,
	input wire o_select_active_high, o_write_strobe_n, o_output_enable_n,
	input wire [16:0] o_word_address,
	input wire [7:0] o_byte_data_pins
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// Taken requests and one write strobe pulse
	sequence s_rd; i_req_valid && o_req_ready && !i_req_write; endsequence
	sequence s_wr; i_req_valid && o_req_ready && i_req_write; endsequence
	sequence s_pulse; !o_write_strobe_n ##1 o_write_strobe_n; endsequence
	a_read_answer: assert property (s_rd |-> ##[2:3] o_rsp_valid)
		else $error("read answer late");
	a_write_pulse: assert property (s_wr |-> ##4 s_pulse)
		else $error("write pulse missing");
	a_strobe_sel: assert property (!o_write_strobe_n |-> !o_select_active_low_n &&
		o_select_active_high && o_byte_data_pins_oe && o_output_enable_n)
		else $error("strobe without selects");
	a_data_hold: assert property ($rose(o_write_strobe_n) |-> o_byte_data_pins_oe &&
		$stable(o_byte_data_pins) && $stable(o_word_address))
		else $error("write data moved");
	a_addr_setup: assert property ($fell(o_write_strobe_n) |->
		$stable(o_word_address) && $past(o_byte_data_pins_oe)) else $error("no setup");
	a_write_gap: assert property ($rose(o_write_strobe_n) |=> o_write_strobe_n)
		else $error("write gap short");
	a_no_fight: assert property (!o_output_enable_n |-> !o_byte_data_pins_oe)
		else $error("bus fight");
	a_retain_off: assert property (o_retention_ack |-> o_select_active_low_n &&
		!o_select_active_high && o_output_enable_n) else $error("retention selected");
	a_ramp_off: assert property (!i_supply_ok |=> o_select_active_low_n &&
		o_output_enable_n) else $error("selected while ramping");
	a_recover_wait: assert property ($rose(i_supply_ok) |-> !o_req_ready ##1
		(o_output_enable_n && o_write_strobe_n)) else $error("no recovery");
endmodule // sram_host_chk
bind sram_host_ctrl sram_host_chk chk_u (.i_core_clk, .i_rst, .i_req_valid, .i_req_write,
	.o_req_ready, .o_rsp_valid, .i_supply_ok, .o_retention_ack, .o_byte_data_pins_oe,
	.o_select_active_low_n, .o_select_active_high, .o_write_strobe_n, .o_output_enable_n,
	.o_word_address, .o_byte_data_pins);

// ==== testbench.sv ====
// Self-checking bench for the memory host controller
`timescale 1ns/1ps
module testbench;
	logic i_core_clk = 0, i_rst = 1, i_req_valid = 0, i_req_write = 0;
	logic i_retention_req = 0, i_supply_ok = 1;
	logic [16:0] i_req_addr = 0;
	logic [7:0] i_req_wdata = 0, i_byte_data_pins, last_q = 0;
	wire o_req_ready, o_rsp_valid, o_retention_ack, o_byte_data_pins_oe, m_drv;
	wire o_select_active_low_n, o_select_active_high, o_write_strobe_n, o_output_enable_n;
	wire [16:0] o_word_address;
	wire [7:0] o_rsp_rdata, o_byte_data_pins, m_dat;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	always #50 i_core_clk = ~i_core_clk;
	sram_host_ctrl dut_u (.i_core_clk, .i_rst, .i_req_valid, .i_req_write, .i_req_addr,
		.i_req_wdata, .o_req_ready, .o_rsp_rdata, .o_rsp_valid, .i_retention_req, .i_supply_ok,
		.o_retention_ack, .o_word_address, .o_byte_data_pins, .o_byte_data_pins_oe,
		.i_byte_data_pins, .o_select_active_low_n, .o_select_active_high, .o_write_strobe_n,
		.o_output_enable_n);
	sram_model mem_u (.i_addr(o_word_address), .i_data(i_byte_data_pins),
		.i_sel_n(o_select_active_low_n), .i_sel(o_select_active_high),
		.i_we_n(o_write_strobe_n), .i_oe_n(o_output_enable_n), .o_data(m_dat), .o_drive(m_drv));
	// Resolved bus; undriven it shows the inverse of its last level
	always @* i_byte_data_pins = o_byte_data_pins_oe ? o_byte_data_pins : m_drv ? m_dat : ~last_q;
	always @(posedge i_core_clk) last_q <= i_byte_data_pins;
	// Hang guard
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			end_sim();
		end
	end
	task chk(input logic [16:0] g, input logic [16:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task end_sim;
		$display("errors=%0d checks=%0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Holds a request until the edge that takes it
	task req(input logic w, input logic [16:0] a, input logic [7:0] d);
		i_req_valid <= 1;
		i_req_write <= w;
		i_req_addr <= a;
		i_req_wdata <= d;
		@(negedge i_core_clk);
		while (o_req_ready !== 1'b1) @(negedge i_core_clk);
		@(posedge i_core_clk);
	endtask
	task idle;
		i_req_valid <= 0;
		@(posedge i_core_clk);
	endtask
	task rd(input logic [16:0] a, input logic [7:0] e);
		req(0, a, 8'h00);
		i_req_valid <= 0;
		repeat (4) begin
			@(negedge i_core_clk);
			if (o_rsp_valid === 1'b1) break;
		end
		chk({o_rsp_valid, o_rsp_rdata}, {1'b1, e});
		@(posedge i_core_clk);
	endtask
	task t_edges;
		req(1, 17'h1_FFFF, 8'hA5);
		req(1, 17'h0_0000, 8'h5A);
		req(1, 17'h0_0001, 8'h3C);
		idle();
		rd(17'h1_FFFF, 8'hA5);
		rd(17'h0_0000, 8'h5A);
		rd(17'h0_0001, 8'h3C);
	endtask
	task t_overwrite;
		req(1, 17'h0_1234, 8'h11);
		req(1, 17'h0_1234, 8'hEE);
		idle();
		rd(17'h0_1234, 8'hEE);
	endtask
	task t_retain;
		i_retention_req <= 1;
		repeat (2) @(posedge i_core_clk);
		@(negedge i_core_clk);
		chk({o_retention_ack, o_select_active_low_n, o_select_active_high, o_output_enable_n},
			4'b1101);
		@(posedge i_core_clk);
		i_retention_req <= 0;
		@(posedge i_core_clk);
		rd(17'h1_FFFF, 8'hA5);
	endtask
	task t_supply;
		i_supply_ok <= 0;
		repeat (2) @(posedge i_core_clk);
		@(negedge i_core_clk);
		chk({o_select_active_low_n, o_output_enable_n, o_write_strobe_n, o_req_ready},
			4'b1110);
		@(posedge i_core_clk);
		i_supply_ok <= 1;
		@(negedge i_core_clk);
		chk(o_req_ready, 0);
		@(posedge i_core_clk);
		rd(17'h0_0000, 8'h5A);
	endtask
	initial begin
		repeat (6) @(posedge i_core_clk);
		i_rst <= 0;
		@(posedge i_core_clk);
		t_edges();
		t_overwrite();
		t_retain();
		t_supply();
		end_sim();
	end
endmodule // testbench
